// File: inc/pse_seq_pkg.sv
// constants and types shared by the port state sequencer
package pse_seq_pkg;
  localparam int unsigned NUM_PORTS = 5;
  localparam int unsigned CLK_MHZ   = 200;

  // port_config_word_a field positions
  localparam int unsigned CFGA_SOFT_ENABLE   = 0;
  localparam int unsigned CFGA_PIN_EN_MASK   = 1;
  localparam int unsigned CFGA_SOFT_WAKE     = 2;
  localparam int unsigned CFGA_DOWN_WAKE_DIS = 3;
  localparam int unsigned CFGA_UP_WAKE_DIS   = 4;
  localparam int unsigned CFGA_POWER_GRANTED = 5;
  localparam int unsigned CFGA_SOFT_READY    = 6;
  localparam int unsigned CFGA_DET_TMR_DIS   = 11;
  localparam int unsigned CFGA_CLASS_MODE    = 13;
  localparam int unsigned CFGA_END_CLASS     = 14;
  // port_config_word_b field positions
  localparam int unsigned CFGB_SIG_FORCE     = 0;
  localparam int unsigned CFGB_INRUSH_LO     = 2;
  localparam int unsigned CFGB_DELAY_LO      = 4;
  localparam int unsigned CFGB_WAKE_FORCE    = 8;

  localparam int unsigned CFG_W  = 16;
  localparam int unsigned TMR_W  = 32;

  // times in microseconds
  localparam int unsigned IDLE_OVERCURRENT_US = 100;
  localparam int unsigned WAKE_HOLD_US        = 200;
  localparam int unsigned OFF_TIME_US         = 1000;
  localparam int unsigned MFVS_DROP_US        = 1000;
  localparam int unsigned DETECT_LIMIT_US     = 5000;
  localparam int unsigned INRUSH_BASE_US      = 10000;
  localparam int unsigned DELAY_BASE_US       = 100000;

  localparam logic [TMR_W-1:0] IDLE_OC_CYC  = TMR_W'(IDLE_OVERCURRENT_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] WAKE_CYC     = TMR_W'(WAKE_HOLD_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] OFF_CYC      = TMR_W'(OFF_TIME_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] MFVS_CYC     = TMR_W'(MFVS_DROP_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] DETECT_CYC   = TMR_W'(DETECT_LIMIT_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] INRUSH_CYC   = TMR_W'(INRUSH_BASE_US * CLK_MHZ);
  localparam logic [TMR_W-1:0] DELAY_CYC    = TMR_W'(DELAY_BASE_US * CLK_MHZ);

  typedef enum logic [8:0] {
    ST_DISABLED  = 9'h001,
    ST_IDLE      = 9'h002,
    ST_DETECT    = 9'h004,
    ST_POWER_UP  = 9'h008,
    ST_POWER_ON  = 9'h010,
    ST_SETTLE    = 9'h020,
    ST_SLEEP     = 9'h040,
    ST_OVERLOAD  = 9'h080,
    ST_RESTART   = 9'h100
  } port_state_t;
endpackage : pse_seq_pkg

// File: hdl/pse_hold_timer.sv
// condition-hold counter: pulses done after cond has held for limit cycles
`timescale 1ns/1ps
`default_nettype none
module pse_hold_timer
  import pse_seq_pkg::*;
#(
  parameter int unsigned W = TMR_W
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              done
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge mclk) begin
    if (reset || !cond) begin
      cnt_ff <= '0;
    end else if (cnt_ff != limit) begin
      cnt_ff <= cnt_ff + W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (reset || !cond) begin
      done <= 1'b0;
    end else begin
      done <= (cnt_ff == limit - W'(1));
    end
  end
endmodule : pse_hold_timer
`default_nettype wire

// File: hdl/pse_port_fsm.sv
// state machine of one port
`timescale 1ns/1ps
`default_nettype none
module pse_port_fsm
  import pse_seq_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              host_free_sel,
  input  wire logic              wake_pin,
  input  wire logic [CFG_W-1:0]  cfg_a,
  input  wire logic [CFG_W-1:0]  cfg_b,
  input  wire logic              vin_good,
  input  wire logic              out_in_sleep_range,
  input  wire logic              out_below_disable,
  input  wire logic              cur_above_wake_max,
  input  wire logic              cur_in_wake_window,
  input  wire logic              sig_valid,
  input  wire logic              inrush_done,
  input  wire logic              mfvs_valid,
  input  wire logic              overload,
  input  wire logic [TMR_W-1:0]  idle_oc_cyc,
  input  wire logic [TMR_W-1:0]  detect_cyc,
  input  wire logic [TMR_W-1:0]  inrush_base,
  input  wire logic [TMR_W-1:0]  delay_base,
  output port_state_t            state,
  output logic                   high_side_on,
  output logic                   pull_down_on,
  output logic                   sleep_bias_on,
  output logic                   snubber_off,
  output logic                   inrush_timeout
);
  port_state_t  state_ff;
  port_state_t  nxt_state;
  logic [TMR_W-1:0] tmr_ff;
  logic [TMR_W-1:0] delay_lim;
  logic [TMR_W-1:0] inrush_lim;
  logic         idle_oc;
  logic         wake_held;
  logic         mfvs_lost;
  logic         wake_req;
  logic         enabled;

  // 2-bit field scales the base delay by 1,2,4,8
  function automatic logic [TMR_W-1:0] scale(input logic [TMR_W-1:0] b, input logic [1:0] s);
    scale = b << s;
  endfunction : scale

  assign delay_lim  = scale(delay_base, cfg_b[CFGB_DELAY_LO +: 2]);  // see RQ21
  assign inrush_lim = scale(inrush_base, cfg_b[CFGB_INRUSH_LO +: 2]);
  assign enabled    = cfg_a[CFGA_SOFT_ENABLE] ||
                      (host_free_sel && !cfg_a[CFGA_PIN_EN_MASK]);  // see RQ6

  pse_hold_timer u_idle_oc (
    .mclk  (mclk),
    .reset (reset),
    .cond  ((state_ff == ST_IDLE) && cur_above_wake_max),
    .limit (idle_oc_cyc),
    .done  (idle_oc)
  );  // see RQ8

  pse_hold_timer u_wake (
    .mclk  (mclk),
    .reset (reset),
    .cond  ((state_ff == ST_SLEEP) && !cfg_a[CFGA_UP_WAKE_DIS] &&
            (cur_in_wake_window || cfg_b[CFGB_WAKE_FORCE])),
    .limit (WAKE_CYC),
    .done  (wake_held)
  );

  pse_hold_timer u_mfvs (
    .mclk  (mclk),
    .reset (reset),
    .cond  ((state_ff == ST_POWER_ON) && !mfvs_valid),
    .limit (MFVS_CYC),
    .done  (mfvs_lost)
  );

  // user pin, host bit or powered device may wake the port
  assign wake_req = wake_held || cfg_a[CFGA_SOFT_WAKE] ||
                    (wake_pin && !cfg_a[CFGA_DOWN_WAKE_DIS]);  // see RQ13

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_DISABLED: begin
        if (enabled && out_below_disable) begin
          nxt_state = ST_IDLE;  // see RQ6
        end
      end
      ST_IDLE: begin
        if (overload || idle_oc) begin
          nxt_state = ST_OVERLOAD;  // see RQ8 see RQ14
        end else if (out_in_sleep_range && !cur_above_wake_max &&
                     (host_free_sel || cfg_a[CFGA_SOFT_READY])) begin
          nxt_state = ST_DETECT;  // see RQ7 see RQ3
        end
      end
      ST_DETECT: begin
        // host ends classification explicitly; autonomous/plain detect ends on signature
        if (cfg_a[CFGA_END_CLASS] || (!cfg_a[CFGA_CLASS_MODE] &&
            (sig_valid || cfg_b[CFGB_SIG_FORCE]))) begin
          if (cfg_a[CFGA_POWER_GRANTED] && vin_good &&
              (cfg_a[CFGA_END_CLASS] || sig_valid || cfg_b[CFGB_SIG_FORCE])) begin
            nxt_state = ST_POWER_UP;  // see RQ16 see RQ17 see RQ3
          end else begin
            nxt_state = ST_RESTART;  // see RQ20
          end
        end else if (!cfg_a[CFGA_DET_TMR_DIS] && tmr_ff >= detect_cyc) begin
          nxt_state = ST_RESTART;  // see RQ19 see RQ15
        end
      end
      ST_POWER_UP: begin
        if (inrush_done) begin
          nxt_state = ST_POWER_ON;  // see RQ10
        end else if (tmr_ff >= inrush_lim) begin
          nxt_state = ST_RESTART;  // see RQ15
        end
      end
      ST_POWER_ON: begin
        if (overload) begin
          nxt_state = ST_OVERLOAD;  // see RQ11 see RQ14
        end else if (mfvs_lost) begin
          nxt_state = ST_SETTLE;  // see RQ11 see RQ12
        end else if (!cfg_a[CFGA_POWER_GRANTED]) begin
          nxt_state = ST_RESTART;  // see RQ11
        end
      end
      ST_SETTLE: begin
        if (overload || (tmr_ff >= OFF_CYC && !out_in_sleep_range)) begin
          nxt_state = ST_OVERLOAD;  // see RQ14
        end else if (out_in_sleep_range) begin
          nxt_state = ST_SLEEP;  // see RQ13
        end
      end
      ST_SLEEP: begin
        if (overload) begin
          nxt_state = ST_OVERLOAD;  // see RQ14
        end else if (wake_req) begin
          nxt_state = ST_DETECT;  // see RQ13
        end
      end
      ST_OVERLOAD: begin
        if (tmr_ff >= delay_lim) begin
          nxt_state = ST_IDLE;  // see RQ21 see RQ14
        end
      end
      ST_RESTART: begin
        if (tmr_ff >= delay_lim) begin
          nxt_state = ST_IDLE;  // see RQ15
        end
      end
      default: nxt_state = ST_DISABLED;
    endcase
    // clearing the enable always drops the port
    if (!enabled) begin
      nxt_state = ST_DISABLED;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= ST_DISABLED;  // see RQ4
    end else begin
      state_ff <= nxt_state;
    end
  end

  // one state timer, restarted on every transition
  always_ff @(posedge mclk) begin
    if (reset || nxt_state != state_ff) begin
      tmr_ff <= '0;
    end else if (tmr_ff != '1) begin
      tmr_ff <= tmr_ff + TMR_W'(1);  // see RQ22
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state          <= ST_DISABLED;
      high_side_on   <= 1'b0;
      pull_down_on   <= 1'b1;
      sleep_bias_on  <= 1'b0;
      snubber_off    <= 1'b0;
      inrush_timeout <= 1'b0;
    end else begin
      state          <= nxt_state;
      high_side_on   <= (nxt_state == ST_POWER_UP) || (nxt_state == ST_POWER_ON);
      pull_down_on   <= (nxt_state == ST_DISABLED) || (nxt_state == ST_OVERLOAD) ||
                        (nxt_state == ST_SETTLE);  // see RQ5 see RQ21
      sleep_bias_on  <= (nxt_state == ST_IDLE) || (nxt_state == ST_SLEEP) ||
                        (nxt_state == ST_RESTART);  // see RQ7
      snubber_off    <= (nxt_state == ST_DETECT) && cfg_a[CFGA_CLASS_MODE];
      inrush_timeout <= (state_ff == ST_POWER_UP) && (nxt_state == ST_RESTART);
    end
  end
endmodule : pse_port_fsm
`default_nettype wire

// File: hdl/pse_port_state_sequencer.sv
// five-port state sequencer top
// Operation
// RQ1: host checks class group and order
// RQ2: host classifies while port is detecting
// RQ3: select low: host commands each step
// RQ4: reset puts every port disabled
// RQ5: disabled: switch off, pull-down on
// RQ6: soft enable or unmasked pin leaves disabled
// RQ7: idle biases, detects when quiet and ready
// RQ8: idle sustained overcurrent goes to overload
// RQ9: host powers up only compatible class
// RQ10: power-up waits inrush done, then power-on
// RQ11: power-on exits on fault, timeout, withdrawal
// RQ12: lost maintain signature goes settle-sleep
// RQ13: discharge to sleep, wake back to detect
// RQ14: overload: off, wait, then idle
// RQ15: detect or power-up timeout goes restart
// RQ16: select high: power on valid signature
// RQ17: force-valid bit skips detection result
// RQ18: five ports run independently
// RQ19: detect time limit, optional, then restart
// RQ20: no power grant: restart, not power-up
// RQ21: overload delay set by two-bit field
// RQ22: synchronized flags, clocked timeout counters
`timescale 1ns/1ps
`default_nettype none
module pse_port_state_sequencer
  import pse_seq_pkg::*;
#(
  parameter int unsigned N            = NUM_PORTS,
  parameter logic [TMR_W-1:0] IDLE_OC = IDLE_OC_CYC,
  parameter logic [TMR_W-1:0] DETECT  = DETECT_CYC,
  parameter logic [TMR_W-1:0] INRUSH  = INRUSH_CYC,
  parameter logic [TMR_W-1:0] DELAY   = DELAY_CYC
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                host_free_sel,
  input  wire logic                wake_pin,
  input  wire logic                vin_good,
  input  wire logic [N*CFG_W-1:0]  port_config_word_a,
  input  wire logic [N*CFG_W-1:0]  port_config_word_b,
  input  wire logic [N-1:0]        out_in_sleep_range,
  input  wire logic [N-1:0]        out_below_disable,
  input  wire logic [N-1:0]        cur_above_wake_max,
  input  wire logic [N-1:0]        cur_in_wake_window,
  input  wire logic [N-1:0]        sig_valid,
  input  wire logic [N-1:0]        inrush_done,
  input  wire logic [N-1:0]        mfvs_valid,
  input  wire logic [N-1:0]        overload,
  output logic [N*9-1:0]           port_state,
  output logic [N-1:0]             high_side_on,
  output logic [N-1:0]             pull_down_on,
  output logic [N-1:0]             sleep_bias_on,
  output logic [N-1:0]             snubber_off,
  output logic [N-1:0]             inrush_timeout
);
  // flags arrive already synchronized by the analog front end
  genvar p;
  generate
    for (p = 0; p < N; p++) begin : g_port  // see RQ18
      port_state_t st;
      pse_port_fsm u_fsm (
        .mclk               (mclk),
        .reset              (reset),
        .host_free_sel      (host_free_sel),
        .wake_pin           (wake_pin),
        .cfg_a              (port_config_word_a[p*CFG_W +: CFG_W]),
        .cfg_b              (port_config_word_b[p*CFG_W +: CFG_W]),
        .vin_good           (vin_good),
        .out_in_sleep_range (out_in_sleep_range[p]),
        .out_below_disable  (out_below_disable[p]),
        .cur_above_wake_max (cur_above_wake_max[p]),
        .cur_in_wake_window (cur_in_wake_window[p]),
        .sig_valid          (sig_valid[p]),
        .inrush_done        (inrush_done[p]),
        .mfvs_valid         (mfvs_valid[p]),
        .overload           (overload[p]),
        .idle_oc_cyc        (IDLE_OC),
        .detect_cyc         (DETECT),
        .inrush_base        (INRUSH),
        .delay_base         (DELAY),
        .state              (st),
        .high_side_on       (high_side_on[p]),
        .pull_down_on       (pull_down_on[p]),
        .sleep_bias_on      (sleep_bias_on[p]),
        .snubber_off        (snubber_off[p]),
        .inrush_timeout     (inrush_timeout[p])
      );
      assign port_state[p*9 +: 9] = st;
    end
  endgenerate
endmodule : pse_port_state_sequencer
`default_nettype wire

// File: verif/pse_seq_assertions.sv
// port-0 checker, plus last-port idle overcurrent, for the five-port sequencer, bound to the top
`timescale 1ns/1ps
`default_nettype none
module pse_seq_assertions
  import pse_seq_pkg::*;
#(
  parameter int unsigned      N       = NUM_PORTS,
  parameter logic [TMR_W-1:0] IDLE_OC = IDLE_OC_CYC,
  parameter logic [TMR_W-1:0] DETECT  = DETECT_CYC
) (
  input wire logic               mclk,
  input wire logic               reset,
  input wire logic [N*CFG_W-1:0] port_config_word_a,
  input wire logic [N-1:0]       out_in_sleep_range,
  input wire logic [N-1:0]       out_below_disable,
  input wire logic [N-1:0]       cur_above_wake_max,
  input wire logic [N-1:0]       inrush_done,
  input wire logic [N-1:0]       overload,
  input wire logic [N*9-1:0]     port_state,
  input wire logic [N-1:0]       high_side_on,
  input wire logic [N-1:0]       pull_down_on,
  input wire logic [N-1:0]       sleep_bias_on
);
  logic [8:0]       st;
  logic [8:0]       st_last;
  logic [15:0]      cfg;
  logic [TMR_W-1:0] oc_cnt_ff;
  logic [TMR_W-1:0] det_cnt_ff;
  // port 0 is watched; every port is an instance of the same module
  // idle overcurrent count uses the last port, the one the bench loads
  assign st      = port_state[8:0];
  assign st_last = port_state[(N-1)*9 +: 9];
  assign cfg = port_config_word_a[15:0];
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  always_ff @(posedge mclk) begin
    oc_cnt_ff  <= (!reset && st_last == ST_IDLE && cur_above_wake_max[N-1]) ?
                  oc_cnt_ff + 1 : '0;
    det_cnt_ff <= (!reset && st == ST_DETECT && !cfg[CFGA_DET_TMR_DIS]) ? det_cnt_ff + 1 : '0;
  end
  property p_reset_off;
    $fell(reset) |-> st == ST_DISABLED && pull_down_on[0];
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("not disabled after reset");
  property p_dis_out;
    st == ST_DISABLED |-> pull_down_on[0] && !high_side_on[0];
  endproperty
  a_dis_out: assert property (p_dis_out) else $error("disabled port drives output");
  property p_dis_exit;
    st == ST_DISABLED && cfg[0] && out_below_disable[0] |=> st == ST_IDLE;
  endproperty
  a_dis_exit: assert property (p_dis_exit) else $error("enabled port stays disabled");
  property p_idle_bias;
    st == ST_IDLE |-> sleep_bias_on[0] && !high_side_on[0];
  endproperty
  a_idle_bias: assert property (p_idle_bias) else $error("idle port not biased");
  property p_idle_det;
    st == ST_IDLE && cfg[0] && cfg[6] && out_in_sleep_range[0] && !cur_above_wake_max[0]
      && !overload[0] |=> st == ST_DETECT;
  endproperty
  a_idle_det: assert property (p_idle_det) else $error("ready idle port not detecting");
  property p_idle_oc;
    oc_cnt_ff <= IDLE_OC + 2;
  endproperty
  a_idle_oc: assert property (p_idle_oc) else $error("idle overcurrent not acted on");
  property p_det_lim;
    det_cnt_ff <= DETECT + 2;
  endproperty
  a_det_lim: assert property (p_det_lim) else $error("detection overran its limit");
  property p_no_grant;
    st == ST_DETECT && !cfg[CFGA_POWER_GRANTED] |=> st != ST_POWER_UP;
  endproperty
  a_no_grant: assert property (p_no_grant) else $error("power-up without grant");
  property p_inrush;
    st == ST_POWER_UP && inrush_done[0] && !overload[0] && cfg[0] && cfg[5] |=> st == ST_POWER_ON;
  endproperty
  a_inrush: assert property (p_inrush) else $error("finished inrush not powered on");
  property p_ovl;
    st == ST_OVERLOAD |-> !high_side_on[0] ##1 st inside {ST_OVERLOAD, ST_IDLE, ST_DISABLED};
  endproperty
  a_ovl: assert property (p_ovl) else $error("overload not off or bad exit");
endmodule : pse_seq_assertions
bind pse_port_state_sequencer pse_seq_assertions #(.N(N), .IDLE_OC(IDLE_OC), .DETECT(DETECT))
  u_pse_seq_assertions (
  .mclk               (mclk),
  .reset              (reset),
  .port_config_word_a (port_config_word_a),
  .out_in_sleep_range (out_in_sleep_range),
  .out_below_disable  (out_below_disable),
  .cur_above_wake_max (cur_above_wake_max),
  .inrush_done        (inrush_done),
  .overload           (overload),
  .port_state         (port_state),
  .high_side_on       (high_side_on),
  .pull_down_on       (pull_down_on),
  .sleep_bias_on      (sleep_bias_on)
);
`default_nettype wire

// File: verif/pse_pd_model.sv
// powered-device model: the comparator flags each port sees
`timescale 1ns/1ps
`default_nettype none
module pse_pd_model
  import pse_seq_pkg::*;
#(
  parameter int unsigned N = NUM_PORTS
) (
  input  wire logic         mclk,
  input  wire logic [N-1:0] present,
  input  wire logic [N-1:0] slow,
  input  wire logic [N-1:0] high_side_on,
  input  wire logic [N-1:0] pull_down_on,
  output logic [N-1:0]      sig_valid,
  output logic [N-1:0]      inrush_done,
  output logic [N-1:0]      mfvs_valid,
  output logic [N-1:0]      out_in_sleep_range,
  output logic [N-1:0]      out_below_disable
);
  logic [1:0] ramp_ff [N];
  // output needs three cycles to ramp once the switch closes
  always_ff @(posedge mclk) begin
    for (int p = 0; p < N; p++) begin
      ramp_ff[p] <= !high_side_on[p] ? 2'h0 : (ramp_ff[p] == 2'h3 ? 2'h3 : ramp_ff[p] + 2'h1);
    end
  end
  // a slow device never finishes inrush, so the timeout gets exercised
  always_comb begin
    for (int p = 0; p < N; p++) begin
      inrush_done[p] = present[p] && !slow[p] && ramp_ff[p] == 2'h3;
    end
  end
  assign sig_valid          = present;
  assign mfvs_valid         = present & high_side_on;
  assign out_in_sleep_range = ~high_side_on;
  assign out_below_disable  = pull_down_on;
endmodule : pse_pd_model
`default_nettype wire

// File: verif/pse_port_state_sequencer_tb.sv
// bench: host steps the ports, the model plays the devices
`timescale 1ns/1ps
`default_nettype none
module pse_port_state_sequencer_tb
  import pse_seq_pkg::*;
;
  localparam int unsigned N = NUM_PORTS;
  logic               mclk;
  logic               reset         = 1'b1;
  logic               host_free_sel = 1'b0;
  logic               wake_pin      = 1'b0;
  logic [N*CFG_W-1:0] cfg_a         = '0;
  logic [N*CFG_W-1:0] cfg_b         = '0;
  logic [N-1:0]       present       = 5'h07;
  logic [N-1:0]       slow          = 5'h02;
  logic [N-1:0]       oc            = 5'h10;
  logic [N-1:0]       ovl           = '0;
  logic               vin_ok        = 1'b1;
  logic [N-1:0]       wake_cur      = '0;
  logic [N-1:0]       below, in_rng, sig, ird, mfvs, hs, pd, bias, snub, itmo;
  logic [N*9-1:0]     st;
  int                 error_cnt = 0;
  int                 checked   = 0;
  int                 cycles    = 0;

  pse_port_state_sequencer #(.IDLE_OC(8), .DETECT(20), .INRUSH(20), .DELAY(10))
    u_pse_port_state_sequencer (
    .mclk(mclk), .reset(reset), .host_free_sel(host_free_sel), .wake_pin(wake_pin),
    .vin_good(vin_ok), .port_config_word_a(cfg_a), .port_config_word_b(cfg_b),
    .out_in_sleep_range(in_rng), .out_below_disable(below), .cur_above_wake_max(oc),
    .cur_in_wake_window(wake_cur), .sig_valid(sig), .inrush_done(ird), .mfvs_valid(mfvs),
    .overload(ovl), .port_state(st), .high_side_on(hs), .pull_down_on(pd),
    .sleep_bias_on(bias), .snubber_off(snub), .inrush_timeout(itmo));
  pse_pd_model u_pse_pd_model (
    .mclk(mclk), .present(present), .slow(slow), .high_side_on(hs), .pull_down_on(pd),
    .sig_valid(sig), .inrush_done(ird), .mfvs_valid(mfvs), .out_in_sleep_range(in_rng),
    .out_below_disable(below));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic tally_and_finish;
    $display("checked %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // runaway guard, well above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [8:0] st_of(input int p);
    return st[p*9 +: 9];
  endfunction : st_of

  // host writes a port's first configuration word
  task automatic set_a(input int p, input logic [15:0] v);
    @(posedge mclk);
    cfg_a[p*16 +: 16] <= v;
    #1;
  endtask : set_a

  task automatic wait_st(input int p, input port_state_t s, input int lim);
    for (int i = 0; i < lim && st_of(p) !== s; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(st_of(p), s);
  endtask : wait_st

  // host pairing check: same voltage group, source class not below device
  function automatic logic [15:0] grant(input int pse, input int dev);
    return 16'(((pse <= 12) == (dev <= 12)) && pse >= dev) << 5;
  endfunction : grant

  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    #1;
    for (int p = 0; p < N; p++) chk(st_of(p), ST_DISABLED);
    chk(pd, 9'h1f);
    chk(hs, 9'h00);
    set_a(0, 16'h0001);
    wait_st(0, ST_IDLE, 4);
    chk(bias[0], 1'b1);
    repeat (10) @(posedge mclk);
    #1;
    chk(st_of(0), ST_IDLE);
    chk(st_of(1), ST_DISABLED);
    set_a(0, 16'h2041);
    wait_st(0, ST_DETECT, 4);
    chk(snub[0], 1'b1);
    wait_st(0, ST_RESTART, 30);
    wait_st(0, ST_IDLE, 20);
    wait_st(0, ST_DETECT, 4);
    set_a(0, 16'h6041 | grant(10, 13));
    wait_st(0, ST_RESTART, 4);
    set_a(0, 16'h2041);
    wait_st(0, ST_DETECT, 24);
    set_a(0, 16'h6041 | grant(12, 11));
    wait_st(0, ST_POWER_UP, 4);
    chk(hs[0], 1'b1);
    wait_st(0, ST_POWER_ON, 8);
    set_a(0, 16'h2061);
    repeat (10) @(posedge mclk);
    #1;
    chk(st_of(0), ST_POWER_ON);
    @(posedge mclk);
    ovl[0] <= 1'b1;
    #1;
    wait_st(0, ST_OVERLOAD, 4);
    chk(hs[0], 1'b0);
    @(posedge mclk);
    ovl[0] <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk(st_of(0), ST_OVERLOAD);
    wait_st(0, ST_IDLE, 15);
    set_a(0, 16'h6061);
    wait_st(0, ST_POWER_ON, 12);
    set_a(0, 16'h6041);
    wait_st(0, ST_RESTART, 4);
    set_a(0, 16'h0000);
    wait_st(0, ST_DISABLED, 4);
    // supply not good: a granted signature must still end in restart
    @(posedge mclk);
    vin_ok <= 1'b0;
    set_a(1, 16'h0061);
    wait_st(1, ST_RESTART, 10);
    @(posedge mclk);
    vin_ok <= 1'b1;
    #1;
    wait_st(1, ST_POWER_UP, 20);
    wait_st(1, ST_RESTART, 30);
    chk(itmo[1], 1'b1);
    set_a(4, 16'h0041);
    wait_st(4, ST_IDLE, 4);
    repeat (4) @(posedge mclk);
    #1;
    chk(st_of(4), ST_IDLE);
    wait_st(4, ST_OVERLOAD, 10);
    @(posedge mclk);
    host_free_sel <= 1'b1;
    cfg_a[32 +: 32] <= 32'h0022_0020;
    cfg_b[48] <= 1'b1;
    #1;
    wait_st(2, ST_POWER_UP, 12);
    chk(st_of(3), ST_DISABLED);
    set_a(3, 16'h0021);
    wait_st(3, ST_POWER_UP, 12);
    tally_and_finish();
  end
endmodule : pse_port_state_sequencer_tb
`default_nettype wire
